// ===== hw/record_ram.sv
// Dual-port control-data memory with registered read data.
module record_ram #(
  parameter int AW = 7,
  parameter int DW = 32
) (
  input  wire logic          clk_i,
  input  wire logic          a_we_i,
  input  wire logic [AW-1:0] a_addr_i,
  input  wire logic [DW-1:0] a_wdata_i,
  output logic      [DW-1:0] a_rdata_o,
  input  wire logic          b_we_i,
  input  wire logic [AW-1:0] b_addr_i,
  input  wire logic [DW-1:0] b_wdata_i,
  output logic      [DW-1:0] b_rdata_o
);
  logic [DW-1:0] mem [2**AW];

  // Software and the engine touching one word in one cycle is a race; the engine wins.
  always_ff @(posedge clk_i)
  begin
    if (a_we_i)
    begin
      mem[a_addr_i] <= a_wdata_i;
    end
    if (b_we_i)
    begin
      mem[b_addr_i] <= b_wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    a_rdata_o <= mem[a_addr_i];
    b_rdata_o <= mem[b_addr_i];
  end
endmodule // record_ram

// ===== hw/transfer_engine.sv
// Event-triggered transfer engine with AHB-Lite registers and control-data memory.
// Operation
// - Clock gate bit 3 low keeps engine idle
// - Five enable registers gate each trigger
// - Base register places control-data records
// - Bit 6 selects 8 or 16-bit units
// - Bit 4 chains next record
// - Bit 3 steps destination address
// - Bit 2 steps source address
// - Bit 0 selects normal or repeat
// - Block size gives units per activation
// - Transfer count gives activations per record
// - Reload count restores count in repeat
// - Record holds 16-bit source address
// - Record holds 16-bit destination address
// - Serial end starts only with enable bit
module transfer_engine
  import xfer_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                hsel_i,
  input  wire logic [31:0]         haddr_i,
  input  wire logic [1:0]          htrans_i,
  input  wire logic                hwrite_i,
  input  wire logic [2:0]          hsize_i,
  input  wire logic [31:0]         hwdata_i,
  input  wire logic                hready_i,
  output logic      [31:0]         hrdata_o,
  output logic                     hreadyout_o,
  output logic                     hresp_o,
  input  wire logic [NUM_TRIG-1:0] trig_i,
  output logic                     mem_req_o,
  output logic                     mem_we_o,
  output logic                     mem_wide_o,
  output logic      [15:0]         mem_addr_o,
  output logic      [15:0]         mem_wdata_o,
  input  wire logic                mem_ack_i,
  input  wire logic [15:0]         mem_rdata_i,
  output logic                     irq_o,
  output logic      [VEC_W-1:0]    irq_vec_o,
  output logic                     busy_o
);
  logic [7:0]          gate_reg_ff;
  logic [NUM_TRIG-1:0] en_ff;
  logic [7:0]          base_ff;
  logic [NUM_TRIG-1:0] pend_ff;
  logic                wr_ff;
  logic [1:0]          rd_stage_ff;
  logic [11:0]         addr_ff;
  logic                hresp_ff;
  state_t              state_ff;
  logic [VEC_W-1:0]    vec_ff;
  logic [REC_AW-1:0]   rec_ff;
  logic [7:0]          ctl_ff;
  logic [7:0]          block_ff;
  logic [7:0]          cnt_ff;
  logic [7:0]          reload_ff;
  logic [15:0]         src_ff;
  logic [15:0]         dst_ff;
  logic [8:0]          units_ff;
  logic                gate;
  logic                addr_phase;
  logic                in_ram;
  logic [31:0]         rd_mux;
  logic [31:0]         ram_a_q;
  logic [31:0]         ram_b_q;
  logic                b_we;
  logic [REC_AW-1:0]   b_addr;
  logic [31:0]         b_wdata;
  logic [7:0]          nxt_cnt;
  logic [VEC_W-1:0]    pick;
  logic                start;
  logic                hold;
  logic                buf_in_ready;
  logic                buf_out_valid;
  logic [15:0]         buf_out;
  logic                clr_en;
  logic [31:0]         rd_mux_ff;
  logic                hreadyout_ff;

  assign gate       = gate_reg_ff[CLK_GATE_BIT];
  assign addr_phase = hsel_i & htrans_i[1] & hready_i;
  assign in_ram     = (addr_ff[11:9] == RAM_SEL);
  assign hrdata_o    = rd_mux_ff;
  assign hreadyout_o = hreadyout_ff;
  assign hresp_o     = hresp_ff;

  // Lowest pending trigger number wins when several wait.
  function automatic logic [VEC_W-1:0] first_set(input logic [NUM_TRIG-1:0] v);
    logic [VEC_W-1:0] r;
    r = '0;
    for (int i = NUM_TRIG - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = VEC_W'(i);
      end
    end
    return r;
  endfunction

  assign pick  = first_set(pend_ff);
  assign start = (state_ff == ST_IDLE) & gate & (|pend_ff);

  // Register readback.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (in_ram)
    begin
      rd_mux = ram_a_q;
    end
    else if (addr_ff == OFF_CLK_GATE)
    begin
      rd_mux = {24'h00_0000, gate_reg_ff};
    end
    else if (addr_ff >= OFF_EN_FIRST && addr_ff <= OFF_EN_LAST && addr_ff[1:0] == 2'b00)
    begin
      rd_mux = {24'h00_0000, en_ff[8*(32'(addr_ff - OFF_EN_FIRST) >> 2) +: 8]};
    end
    else if (addr_ff == OFF_BASE)
    begin
      rd_mux = {24'h00_0000, base_ff};
    end
    else if (addr_ff == OFF_STATUS)
    begin
      rd_mux = {16'h0000, busy_o, 1'b0, 4'(state_ff), 2'b00, 2'b00, vec_ff};
    end
  end

  // Bus slave: writes take no wait state, reads take two.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ff        <= 1'b0;
      rd_stage_ff  <= 2'h0;
      addr_ff      <= 12'h000;
      hreadyout_ff <= 1'b1;
      rd_mux_ff    <= 32'h0000_0000;
      hresp_ff     <= 1'b0;
    end
    else
    begin
      wr_ff <= addr_phase & hwrite_i;
      if (addr_phase)
      begin
        addr_ff <= haddr_i[11:0];
      end
      if (addr_phase & ~hwrite_i)
      begin
        rd_stage_ff  <= 2'h1;
        hreadyout_ff <= 1'b0;
      end
      else if (rd_stage_ff == 2'h1)
      begin
        rd_stage_ff <= 2'h2;
      end
      else if (rd_stage_ff == 2'h2)
      begin
        rd_mux_ff    <= rd_mux;
        hreadyout_ff <= 1'b1;
        rd_stage_ff  <= 2'h0;
      end
    end
  end

  // Software-written configuration.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gate_reg_ff <= CLK_GATE_RST;
      en_ff       <= {NUM_EN_REGS{EN_RST}};
      base_ff     <= BASE_RST;
    end
    else
    begin
      if (clr_en)
      begin
        en_ff[vec_ff] <= 1'b0;
      end
      if (wr_ff && addr_ff == OFF_CLK_GATE)
      begin
        gate_reg_ff <= hwdata_i[7:0] & CLK_GATE_MASK;
      end
      else if (wr_ff && addr_ff >= OFF_EN_FIRST && addr_ff <= OFF_EN_LAST
               && addr_ff[1:0] == 2'b00)
      begin
        en_ff[8*(32'(addr_ff - OFF_EN_FIRST) >> 2) +: 8] <= hwdata_i[7:0];
      end
      else if (wr_ff && addr_ff == OFF_BASE)
      begin
        base_ff <= hwdata_i[7:0];
      end
    end
  end

  // A trigger arriving as its pending bit is taken is kept, not lost.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_ff <= '0;
    end
    else
    begin
      pend_ff <= (pend_ff & ~(NUM_TRIG'(start) << pick))
                 | (trig_i & en_ff & {NUM_TRIG{gate}});
    end
  end

  assign nxt_cnt = cnt_ff - 8'h01;
  assign clr_en  = (state_ff == ST_WBACK0) & ~ctl_ff[CTL_REPEAT] & (nxt_cnt == 8'h00);

  // Record port: fetch two words, write them back updated.
  always_comb
  begin
    b_we    = 1'b0;
    b_addr  = rec_ff;
    b_wdata = 32'h0000_0000;
    case (state_ff)
      ST_FETCH1: b_addr = rec_ff + REC_AW'(1);
      ST_WBACK0:
      begin
        b_we    = 1'b1;
        b_wdata = {reload_ff,
                   (ctl_ff[CTL_REPEAT] && nxt_cnt == 8'h00) ? reload_ff : nxt_cnt,
                   block_ff, ctl_ff};
      end
      ST_WBACK1:
      begin
        b_we    = 1'b1;
        b_addr  = rec_ff + REC_AW'(1);
        b_wdata = {dst_ff, src_ff};
      end
      default: b_we = 1'b0;
    endcase
  end

  // Request-issuing states stall while the clock gate is off.
  assign hold = ~gate & (state_ff == ST_FETCH0 || state_ff == ST_RD_REQ
                         || state_ff == ST_WR_REQ);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff    <= ST_IDLE;
      vec_ff      <= '0;
      rec_ff      <= '0;
      ctl_ff      <= 8'h00;
      block_ff    <= 8'h00;
      cnt_ff      <= 8'h00;
      reload_ff   <= 8'h00;
      src_ff      <= 16'h0000;
      dst_ff      <= 16'h0000;
      units_ff    <= 9'h000;
      busy_o      <= 1'b0;
      irq_o       <= 1'b0;
      irq_vec_o   <= '0;
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_wide_o  <= 1'b0;
      mem_addr_o  <= 16'h0000;
      mem_wdata_o <= 16'h0000;
    end
    else if (!hold)
    begin
      irq_o <= 1'b0;
      case (state_ff)
        ST_IDLE:
          if (start)
          begin
            vec_ff   <= pick;
            rec_ff   <= rec_addr(base_ff, pick);
            busy_o   <= 1'b1;
            state_ff <= ST_FETCH0;
          end
        ST_FETCH0: state_ff <= ST_FETCH1;
        ST_FETCH1:
        begin
          ctl_ff    <= ram_b_q[F_CTL +: 8];
          block_ff  <= ram_b_q[F_BLOCK +: 8];
          cnt_ff    <= ram_b_q[F_COUNT +: 8];
          reload_ff <= ram_b_q[F_RELOAD +: 8];
          units_ff  <= (ram_b_q[F_BLOCK +: 8] == 8'h00) ? 9'h100
                       : {1'b0, ram_b_q[F_BLOCK +: 8]};
          state_ff  <= ST_FETCH2;
        end
        ST_FETCH2:
        begin
          src_ff   <= ram_b_q[F_SRC +: 16];
          dst_ff   <= ram_b_q[F_DST +: 16];
          state_ff <= ST_RD_REQ;
        end
        ST_RD_REQ:
          if (buf_in_ready)
          begin
            mem_req_o  <= 1'b1;
            mem_we_o   <= 1'b0;
            mem_wide_o <= ctl_ff[CTL_WIDE];
            mem_addr_o <= src_ff;
            state_ff   <= ST_RD_WT;
          end
        ST_RD_WT:
          if (mem_ack_i)
          begin
            mem_req_o <= 1'b0;
            if (ctl_ff[CTL_SRC_STEP])
            begin
              src_ff <= src_ff + unit_step(ctl_ff[CTL_WIDE]);
            end
            state_ff <= ST_WR_REQ;
          end
        ST_WR_REQ:
          if (buf_out_valid)
          begin
            mem_req_o   <= 1'b1;
            mem_we_o    <= 1'b1;
            mem_addr_o  <= dst_ff;
            mem_wdata_o <= ctl_ff[CTL_WIDE] ? buf_out : {8'h00, buf_out[7:0]};
            state_ff    <= ST_WR_WT;
          end
        ST_WR_WT:
          if (mem_ack_i)
          begin
            mem_req_o <= 1'b0;
            mem_we_o  <= 1'b0;
            if (ctl_ff[CTL_DST_STEP])
            begin
              dst_ff <= dst_ff + unit_step(ctl_ff[CTL_WIDE]);
            end
            units_ff <= units_ff - 9'h001;
            state_ff <= (units_ff == 9'h001) ? ST_WBACK0 : ST_RD_REQ;
          end
        ST_WBACK0:
        begin
          cnt_ff <= (ctl_ff[CTL_REPEAT] && nxt_cnt == 8'h00) ? reload_ff : nxt_cnt;
          if (clr_en)
          begin
            irq_o     <= 1'b1;
            irq_vec_o <= vec_ff;
          end
          state_ff <= ST_WBACK1;
        end
        ST_WBACK1:
          if (ctl_ff[CTL_CHAIN])
          begin
            rec_ff   <= rec_ff + REC_AW'(2);
            state_ff <= ST_FETCH0;
          end
          else
          begin
            busy_o   <= 1'b0;
            state_ff <= ST_IDLE;
          end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  record_ram #(.AW(REC_AW), .DW(RAM_DW)) u_ram (
    .clk_i     (clk_i),
    .a_we_i    (wr_ff & in_ram),
    .a_addr_i  (addr_ff[REC_AW+1:2]),
    .a_wdata_i (hwdata_i),
    .a_rdata_o (ram_a_q),
    .b_we_i    (b_we),
    .b_addr_i  (b_addr),
    .b_wdata_i (b_wdata),
    .b_rdata_o (ram_b_q)
  );

  unit_buffer #(.WIDTH(16)) u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  ((state_ff == ST_RD_WT) & mem_ack_i),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (mem_rdata_i),
    .out_valid_o (buf_out_valid),
    .out_ready_i ((state_ff == ST_WR_REQ) & ~hold),
    .out_data_o  (buf_out)
  );

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  gate_off_idle_a: assert property ((state_ff == ST_IDLE) && !gate |=> state_ff == ST_IDLE)
    else $error("engine left idle with clock gate off");
  trig_blocked_a: assert property (!en_ff[0] && !pend_ff[0] |=> !pend_ff[0])
    else $error("disabled trigger became pending");
  serial_end_a: assert property (!en_ff[SERIAL_END_VEC] && !pend_ff[SERIAL_END_VEC]
    |=> !pend_ff[SERIAL_END_VEC])
    else $error("serial end pending while disabled");
  record_base_a: assert property (start |=> rec_ff == rec_addr($past(base_ff), $past(pick)))
    else $error("record address not taken from base");
  src_step_a: assert property ((state_ff == ST_RD_WT) && mem_ack_i && ctl_ff[CTL_SRC_STEP]
    |=> src_ff == $past(src_ff) + (ctl_ff[CTL_WIDE] ? 16'h0002 : 16'h0001))
    else $error("source address step wrong");
  dst_fixed_a: assert property ((state_ff == ST_WR_WT) && !ctl_ff[CTL_DST_STEP]
    |=> $stable(dst_ff))
    else $error("fixed destination moved");
  chain_next_a: assert property ((state_ff == ST_WBACK1) && ctl_ff[CTL_CHAIN]
    |=> state_ff == ST_FETCH0 ##1 state_ff == ST_FETCH1)
    else $error("chain did not fetch next record");
  irq_normal_a: assert property (irq_o |-> !ctl_ff[CTL_REPEAT] && $past(cnt_ff) == 8'h01)
    else $error("interrupt without normal count end");
  count_reload_a: assert property ((state_ff == ST_WBACK0) && ctl_ff[CTL_REPEAT]
    && cnt_ff == 8'h01 |=> cnt_ff == reload_ff)
    else $error("repeat count not reloaded");
  writeback_a: assert property ((state_ff == ST_WR_WT) && mem_ack_i && units_ff == 9'h001
    |=> b_we ##1 b_we)
    else $error("record not written back");
endmodule // transfer_engine

// ===== hw/unit_buffer.sv
// Two-entry valid/ready buffer for transferred units.
module unit_buffer #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] slot_ff [2];
  logic             wptr_ff;
  logic             rptr_ff;
  logic [1:0]       count_ff;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_ff != 2'h2);
  assign out_valid_o = (count_ff != 2'h0);
  assign out_data_o  = slot_ff[rptr_ff];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_ready_i & out_valid_o;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      slot_ff[wptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wptr_ff  <= 1'b0;
      rptr_ff  <= 1'b0;
      count_ff <= 2'h0;
    end
    else
    begin
      wptr_ff  <= wptr_ff ^ push;
      rptr_ff  <= rptr_ff ^ pop;
      count_ff <= count_ff + 2'(push) - 2'(pop);
    end
  end
endmodule // unit_buffer

// ===== hw/xfer_pkg.sv
// Shared constants, register map and types of the event-triggered transfer engine.
package xfer_pkg;

  localparam int NUM_EN_REGS = 5;
  localparam int NUM_TRIG    = 40;
  localparam int VEC_W       = 6;
  localparam int REC_AW      = 7;
  localparam int RAM_DW      = 32;

  localparam logic [11:0] OFF_CLK_GATE = 12'h000;
  localparam logic [11:0] OFF_EN_FIRST = 12'h004;
  localparam logic [11:0] OFF_EN_LAST  = 12'h014;
  localparam logic [11:0] OFF_BASE     = 12'h018;
  localparam logic [11:0] OFF_STATUS   = 12'h01C;
  localparam logic [2:0]  RAM_SEL      = 3'h1;

  localparam int          CLK_GATE_BIT  = 3;
  localparam logic [7:0]  CLK_GATE_MASK = 8'hF9;
  localparam logic [7:0]  CLK_GATE_RST  = 8'h00;
  localparam logic [7:0]  EN_RST        = 8'h00;
  localparam logic [7:0]  BASE_RST      = 8'h00;
  localparam int          SERIAL_END_VEC = 11;

  localparam int CTL_WIDE     = 6;
  localparam int CTL_CHAIN    = 4;
  localparam int CTL_DST_STEP = 3;
  localparam int CTL_SRC_STEP = 2;
  localparam int CTL_REPEAT   = 0;

  localparam int F_CTL    = 0;
  localparam int F_BLOCK  = 8;
  localparam int F_COUNT  = 16;
  localparam int F_RELOAD = 24;
  localparam int F_SRC    = 0;
  localparam int F_DST    = 16;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_FETCH0 = 4'b0001,
    ST_FETCH1 = 4'b0010,
    ST_FETCH2 = 4'b0011,
    ST_RD_REQ = 4'b0100,
    ST_RD_WT  = 4'b0101,
    ST_WR_REQ = 4'b0110,
    ST_WR_WT  = 4'b0111,
    ST_WBACK0 = 4'b1000,
    ST_WBACK1 = 4'b1001
  } state_t;

  function automatic logic [REC_AW-1:0] rec_addr(input logic [7:0] base,
                                                 input logic [VEC_W-1:0] vec);
    return REC_AW'(base) + REC_AW'({vec, 1'b0});
  endfunction

  function automatic logic [15:0] unit_step(input logic wide);
    return wide ? 16'h0002 : 16'h0001;
  endfunction

endpackage

// ===== verification/event_triggered_data_transfer_tb_top.sv
// Self-checking bench of the transfer engine against a queue-free integer model.
module event_triggered_data_transfer_tb_top;
  import xfer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] BASE = 8'h10;
  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                hsel, hwrite, hreadyout, hresp, irq, busy;
  logic                mem_req, mem_we, mem_wide, mem_ack;
  logic [31:0]         haddr, hwdata, hrdata, q;
  logic [1:0]          htrans, ack_delay;
  logic [2:0]          hsize;
  logic [NUM_TRIG-1:0] trig;
  logic [15:0]         mem_addr, mem_wdata, mem_rdata;
  logic [VEC_W-1:0]    irq_vec, irq_v;
  logic [7:0]          bmem [0:65535];
  int                  fails = 0, n_tests = 0, seed = 64, irq_cnt = 0, busy_cyc = 0, i0;
  int                  ctl[64], blk[64], cnt[64], rld[64], src[64], dst[64];
  int                  vl[5] = '{2, 11, 19, 28, 37};

  transfer_engine i_dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .trig_i(trig), .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_wide_o(mem_wide),
    .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_ack_i(mem_ack),
    .mem_rdata_i(mem_rdata), .irq_o(irq), .irq_vec_o(irq_vec), .busy_o(busy));
  mem_partner i_mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_req), .we_i(mem_we),
    .wide_i(mem_wide), .addr_i(mem_addr), .wdata_i(mem_wdata), .delay_i(ack_delay),
    .ack_o(mem_ack), .rdata_o(mem_rdata));

  always #25 clk_i = ~clk_i;

  always @(posedge clk_i)
  begin
    if (irq === 1'b1)
    begin
      irq_cnt++;
      irq_v = irq_vec;
    end
    if (busy === 1'b1)
      busy_cyc++;
    ack_delay <= 2'($random(seed));
  end

  task automatic complete_run;
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s: %h vs %h", $time, what, got, exp);
    end
  endtask

  // The master holds each phase until hready is seen high at a rising edge.
  // It is entered just after a rising edge and leaves just after the edge that ends the data phase.
  task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk_i);
    while (hreadyout !== 1'b1) @(posedge clk_i);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk_i);
    while (hreadyout !== 1'b1) @(posedge clk_i);
    q = hrdata;
    check({31'h0, hresp}, 32'h0, "response");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string what);
    bus(a, 1'b0, 32'h0);
    check(q, e, what);
  endtask

  function automatic logic [11:0] rec_off(input int v);
    return 12'h200 + 12'(4 * ((BASE + 2 * v) % 128));
  endfunction

  function automatic logic [11:0] en_off(input int v);
    return OFF_EN_FIRST + 12'(4 * (v / 8));
  endfunction

  task automatic set_rec(input int v, input int c, input int b, input int n, input int r,
                         input int s, input int d);
    ctl[v] = c;
    blk[v] = b;
    cnt[v] = n;
    rld[v] = r;
    src[v] = s;
    dst[v] = d;
    wr(rec_off(v), {8'(r), 8'(n), 8'(b), 8'(c)});
    wr(rec_off(v) + 12'h004, {16'(d), 16'(s)});
  endtask

  task automatic chk_rec(input int v);
    rd_chk(rec_off(v), {8'(rld[v]), 8'(cnt[v]), 8'(blk[v]), 8'(ctl[v])}, "record word0");
    rd_chk(rec_off(v) + 12'h004, {16'(dst[v]), 16'(src[v])}, "record word1");
  endtask

  task automatic chk_mem;
    for (int a = 16'he900; a < 16'he940; a++)
      check({24'h0, i_mem.mem[a]}, {24'h0, bmem[a]}, "memory");
  endtask

  task automatic model(input int v);
    int         s;
    int         st;
    logic [7:0] c;
    s = v;
    do
    begin
      c  = 8'(ctl[s]);
      st = c[CTL_WIDE] ? 2 : 1;
      repeat (blk[s] == 0 ? 256 : blk[s])
      begin
        bmem[dst[s]] = bmem[src[s]];
        if (c[CTL_WIDE])
          bmem[(dst[s] + 1) % 65536] = bmem[(src[s] + 1) % 65536];
        if (c[CTL_SRC_STEP])
          src[s] = (src[s] + st) % 65536;
        if (c[CTL_DST_STEP])
          dst[s] = (dst[s] + st) % 65536;
      end
      cnt[s] = (cnt[s] + 255) % 256;
      if (cnt[s] == 0 && c[CTL_REPEAT])
        cnt[s] = rld[s];
      s++;
    end
    while (c[CTL_CHAIN]);
  endtask

  task automatic fire(input int v, input bit run);
    int b0;
    b0 = busy_cyc;
    @(posedge clk_i);
    trig <= NUM_TRIG'(1) << v;
    @(posedge clk_i);
    trig <= '0;
    if (run)
    begin
      while (busy !== 1'b1) @(negedge clk_i);
      while (busy !== 1'b0) @(negedge clk_i);
      repeat (3) @(posedge clk_i);
      model(v);
    end
    else
    begin
      repeat (30) @(posedge clk_i);
      check(32'(busy_cyc - b0), 32'h0, "engine ran");
    end
  endtask

  initial
  begin
    hsel      = 1'b0;
    haddr     = 32'h0;
    htrans    = 2'b00;
    hwrite    = 1'b0;
    hsize     = 3'b010;
    hwdata    = 32'h0;
    trig      = '0;
    ack_delay = 2'b00;
    for (int a = 0; a < 64; a++)
    begin
      bmem[16'hff00 + a]       = 8'($random(seed));
      bmem[16'he900 + a]       = 8'($random(seed));
      i_mem.mem[16'hff00 + a] = bmem[16'hff00 + a];
      i_mem.mem[16'he900 + a] = bmem[16'he900 + a];
    end
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(OFF_CLK_GATE, 32'h0, "gate reset");
    for (int i = 0; i < NUM_EN_REGS; i++)
    begin
      rd_chk(OFF_EN_FIRST + 12'(4 * i), 32'h0, "enable reset");
      wr(OFF_EN_FIRST + 12'(4 * i), 32'(8'ha5 ^ 8'(i)));
      rd_chk(OFF_EN_FIRST + 12'(4 * i), 32'(8'ha5 ^ 8'(i)), "enable rw");
      wr(OFF_EN_FIRST + 12'(4 * i), 32'h0);
    end
    rd_chk(OFF_BASE, 32'h0, "base reset");
    wr(OFF_BASE, {24'h0, BASE});
    rd_chk(OFF_BASE, {24'h0, BASE}, "base rw");
    wr(12'h100, 32'hffff_ffff);
    rd_chk(12'h100, 32'h0, "unmapped");
    wr(OFF_CLK_GATE, 32'h0000_00ff);
    rd_chk(OFF_CLK_GATE, {24'h0, CLK_GATE_MASK}, "gate bits");
    wr(OFF_CLK_GATE, 32'h0);
    set_rec(11, 8'h00, 1, 7, 7, 16'hff10, 16'he900);
    wr(en_off(11), 32'h0000_0008);
    fire(11, 0);
    chk_rec(11);
    wr(OFF_CLK_GATE, 32'h0000_0008);
    wr(en_off(11), 32'h0);
    fire(11, 0);
    wr(en_off(11), 32'h0000_0008);
    fire(11, 1);
    chk_rec(11);
    chk_mem();
    wr(en_off(11), 32'h0);
    set_rec(11, 8'h18, 3, 2, 0, 16'hff20, 16'he910);
    set_rec(12, 8'h44, 2, 5, 0, 16'hff30, 16'he920);
    wr(en_off(11), 32'h0000_0008);
    i0 = irq_cnt;
    fire(11, 1);
    chk_rec(11);
    chk_rec(12);
    chk_mem();
    wr(en_off(11), 32'h0);
    set_rec(11, 8'h0d, 1, 1, 3, 16'hff38, 16'he930);
    wr(en_off(11), 32'h0000_0008);
    fire(11, 1);
    chk_rec(11);
    chk_mem();
    check(32'(irq_cnt), 32'(i0), "no interrupt");
    rd_chk(en_off(11), 32'h0000_0008, "enable kept");
    for (int k = 0; k < 5; k++)
    begin
      wr(en_off(vl[k]), 32'h0);
      set_rec(vl[k], 8'h08, 2, 1, 0, 16'hff00 + k, 16'he934 + 2 * k);
      wr(en_off(vl[k]), 32'(8'h01 << (vl[k] % 8)));
      i0 = irq_cnt;
      fire(vl[k], 1);
      check(32'(irq_cnt), 32'(i0 + 1), "interrupt count");
      check(32'(irq_v), 32'(vl[k]), "interrupt vector");
      rd_chk(en_off(vl[k]), 32'h0, "enable cleared");
      chk_rec(vl[k]);
      chk_mem();
    end
    rd_chk(OFF_STATUS, 32'(vl[4]), "status idle");
    complete_run();
  end

  initial
  begin
    repeat (40000) @(posedge clk_i);
    fails++;
    complete_run();
  end
endmodule // event_triggered_data_transfer_tb_top

// ===== verification/mem_partner.sv
// Behavioural memory that answers the transfer engine's unit requests.
module mem_partner (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic        wide_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [1:0]  delay_i,
  output logic             ack_o,
  output logic      [15:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [0:65535];
  logic [1:0] wait_ff;

  // Read data toggles outside the acknowledge cycle, so a late sample never sees a held value.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o   <= 1'b0;
      wait_ff <= 2'd0;
      rdata_o <= 16'h5a5a;
    end
    else if (ack_o || !req_i || wait_ff < delay_i)
    begin
      ack_o   <= 1'b0;
      wait_ff <= (req_i && !ack_o) ? wait_ff + 2'd1 : 2'd0;
      rdata_o <= ~rdata_o;
    end
    else
    begin
      ack_o   <= 1'b1;
      wait_ff <= 2'd0;
      rdata_o <= {~mem[addr_i], mem[addr_i]};
      if (wide_i)
        rdata_o[15:8] <= mem[addr_i + 16'd1];
      if (we_i)
        mem[addr_i] <= wdata_i[7:0];
      if (we_i && wide_i)
        mem[addr_i + 16'd1] <= wdata_i[15:8];
    end
  end
endmodule // mem_partner
